// ==== verilog/tx_descriptor_handler.sv ====
// transmit descriptor handler: fetches word 0, runs the frame path, writes status back
// assumes a single-beat memory port with request/ack and a frame path with start/done
`timescale 1ns/1ns
module tx_descriptor_handler
(
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  // control
  input  wire logic                              tx_start,
  input  wire logic [31:0]                       ring_base,
  input  wire logic [7:0]                        status_copy_mask,
  input  wire logic                              tx_irq_mode_select,
  // descriptor memory
  output logic                                   mem_req_ff,
  output logic                                   mem_write_ff,
  output logic [31:0]                            mem_addr_ff,
  output logic [31:0]                            mem_wdata_ff,
  input  wire logic                              mem_ack,
  input  wire logic [31:0]                       mem_rdata,
  // frame path
  output logic                                   frame_start_ff,
  output logic [1:0]                             frame_position_ff,
  output logic                                   frame_first_ff,
  output logic                                   frame_last_ff,
  input  wire logic                              frame_done,
  input  wire tx_desc_pkg::frame_result_t        frame_result,
  // status
  output logic                                   writeback_irq_ff,
  output logic                                   active_ff,
  output logic                                   frame_error_seen_ff
);

  typedef enum logic [2:0] {IDLE, FETCH, SEND, WRITE, NEXT} state_t;

  state_t                            state_ff;
  tx_desc_pkg::tx_descriptor_word0_t desc_ff;
  tx_desc_pkg::frame_result_t        result_ff;
  tx_desc_pkg::tx_descriptor_word0_t wb_word;
  logic                              wb_err;
  logic [31:0]                       cur_addr_ff;
  logic                              kick_ff;

  tx_desc_status u_status
  (
    .fetched          (desc_ff),
    .result           (result_ff),
    .status_copy_mask (status_copy_mask),
    .writeback        (wb_word),
    .frame_error_flag (wb_err)
  );

  // a kick arriving mid-walk is held so it is not lost while stalled;
  // a kick seen in idle starts the walk directly and is not held, else the
  // walk would fetch the stalled slot once more after it stops
  always_ff @(posedge clk)
  begin
    if (rst)
      kick_ff <= 1'b0;
    else if (ce)
    begin
      if (tx_start && (state_ff != IDLE))
        kick_ff <= 1'b1;
      else if (state_ff == IDLE)
        kick_ff <= 1'b0;
    end
  end

  // descriptor walk
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff     <= IDLE;
      cur_addr_ff  <= 32'(tx_desc_pkg::RESET_ADDR);
      desc_ff      <= '0;
      result_ff    <= '0;
      mem_req_ff   <= 1'b0;
      mem_write_ff <= 1'b0;
      mem_addr_ff  <= 32'h0;
      mem_wdata_ff <= 32'h0;
      active_ff    <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_ff)
        IDLE:
        begin
          if (tx_start || kick_ff)
          begin
            // resume from the stalled slot, not the ring base
            state_ff   <= FETCH;
            mem_req_ff <= 1'b1;
            mem_write_ff <= 1'b0;
            mem_addr_ff  <= cur_addr_ff;
            active_ff  <= 1'b1;
          end
        end
        FETCH:
        begin
          if (mem_ack)
          begin
            mem_req_ff <= 1'b0;
            desc_ff    <= mem_rdata;
            if (mem_rdata[tx_desc_pkg::OWN_BIT])
              state_ff <= SEND;
            else
            begin
              state_ff  <= IDLE;
              active_ff <= 1'b0;
            end
          end
        end
        SEND:
        begin
          if (frame_done)
          begin
            result_ff <= frame_result;
            state_ff  <= WRITE;
          end
        end
        WRITE:
        begin
          if (!mem_req_ff)
          begin
            mem_req_ff   <= 1'b1;
            mem_write_ff <= 1'b1;
            mem_addr_ff  <= cur_addr_ff;
            mem_wdata_ff <= wb_word;
          end
          else if (mem_ack)
          begin
            mem_req_ff   <= 1'b0;
            mem_write_ff <= 1'b0;
            state_ff     <= NEXT;
          end
        end
        NEXT:
        begin
          if (desc_ff.last_entry)
            cur_addr_ff <= ring_base;
          else
            cur_addr_ff <= cur_addr_ff + 32'(tx_desc_pkg::DESC_STRIDE);
          state_ff     <= FETCH;
          mem_req_ff   <= 1'b1;
          mem_addr_ff  <= desc_ff.last_entry ? ring_base
                          : cur_addr_ff + 32'(tx_desc_pkg::DESC_STRIDE);
        end
        default:
          state_ff <= IDLE;
      endcase
    end
  end

  // frame path hand-off: decode position into first/last of frame
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_start_ff    <= 1'b0;
      frame_position_ff <= tx_desc_pkg::FPOS_MIDDLE;
      frame_first_ff    <= 1'b0;
      frame_last_ff     <= 1'b0;
    end
    else if (ce)
    begin
      frame_start_ff <= (state_ff == FETCH) && mem_ack && mem_rdata[tx_desc_pkg::OWN_BIT];
      if ((state_ff == FETCH) && mem_ack)
      begin
        frame_position_ff <= mem_rdata[tx_desc_pkg::FPOS_HI:tx_desc_pkg::FPOS_LO];
        frame_first_ff    <= mem_rdata[tx_desc_pkg::FPOS_HI];
        frame_last_ff     <= mem_rdata[tx_desc_pkg::FPOS_LO];
      end
    end
  end

  // one-cycle irq after the write-back is acknowledged
  always_ff @(posedge clk)
  begin
    if (rst)
      writeback_irq_ff <= 1'b0;
    else if (ce)
      writeback_irq_ff <= (state_ff == WRITE) && mem_req_ff && mem_ack
                          && desc_ff.wb_irq_req && tx_irq_mode_select;
  end

  // sticky error indicator, cleared only by a kick seen in idle, not by a held kick
  always_ff @(posedge clk)
  begin
    if (rst)
      frame_error_seen_ff <= 1'b0;
    else if (ce)
    begin
      if ((state_ff == WRITE) && !mem_req_ff && wb_err)
        frame_error_seen_ff <= 1'b1;
      else if (tx_start && state_ff == IDLE)
        frame_error_seen_ff <= 1'b0;
    end
  end

  chk_wb_owner_clear: assert property (@(posedge clk) disable iff (rst)
    (mem_req_ff && mem_write_ff) |-> !mem_wdata_ff[tx_desc_pkg::OWN_BIT])
    else $error("write-back keeps ownership set");

  chk_wb_error_flag: assert property (@(posedge clk) disable iff (rst)
    (mem_req_ff && mem_write_ff && result_ff.frame_status_bits[tx_desc_pkg::STAT_HI])
    |-> mem_wdata_ff[tx_desc_pkg::FERR_BIT])
    else $error("status bit eight did not set error");

  chk_mask_blocks_low: assert property (@(posedge clk) disable iff (rst)
    (mem_req_ff && mem_write_ff && !result_ff.aborted
     && result_ff.frame_status_bits[tx_desc_pkg::STAT_HI] == 1'b0
     && (result_ff.frame_status_bits[7:0] & ~status_copy_mask) == 8'h00)
    |-> !mem_wdata_ff[tx_desc_pkg::FERR_BIT])
    else $error("masked low status set error");

  chk_irq_cause: assert property (@(posedge clk) disable iff (rst)
    writeback_irq_ff |-> $past(mem_ack) && $past(mem_write_ff)
                         && desc_ff.wb_irq_req && $past(tx_irq_mode_select))
    else $error("irq without write-back request");

  chk_unowned_stop: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_ff == FETCH && mem_ack && !mem_rdata[tx_desc_pkg::OWN_BIT])
    |=> (state_ff == IDLE && !mem_req_ff))
    else $error("fetch continued past unowned descriptor");

  chk_ring_wrap: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_ff == NEXT && desc_ff.last_entry) |=> mem_addr_ff == ring_base)
    else $error("ring end did not wrap");

  chk_send_owned: assert property (@(posedge clk) disable iff (rst)
    frame_start_ff |-> desc_ff.owned)
    else $error("frame started on unowned descriptor");

  chk_wb_follows: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_ff == SEND && frame_done) |=> ##1 (mem_req_ff && mem_write_ff))
    else $error("no write-back after frame");

  chk_position_copy: assert property (@(posedge clk) disable iff (rst)
    frame_start_ff |-> frame_position_ff == desc_ff.frame_pos)
    else $error("frame position mismatch");

endmodule

// ==== include/tx_desc_pkg.sv ====
// package for the transmit descriptor handler: word 0 field layout, codes, types
// assumes a 32-bit descriptor word 0 and a 9-bit frame status vector
package tx_desc_pkg;

  localparam int OWN_BIT     = 31;
  localparam int RING_END    = 30;
  localparam int FPOS_HI     = 29;
  localparam int FPOS_LO     = 28;
  localparam int FERR_BIT    = 27;
  localparam int WBIRQ_BIT   = 26;
  localparam int STAT_W      = 9;
  localparam int STAT_HI     = 8;
  localparam int ADDR_W      = 32;
  localparam int RESET_ADDR  = 0;
  localparam int DESC_STRIDE = 16;

  localparam logic [1:0] FPOS_MIDDLE = 2'h0;
  localparam logic [1:0] FPOS_END    = 2'h1;
  localparam logic [1:0] FPOS_START  = 2'h2;
  localparam logic [1:0] FPOS_SINGLE = 2'h3;

  // decoded first descriptor word
  typedef struct packed {
    logic       owned;
    logic       last_entry;
    logic [1:0] frame_pos;
    logic       frame_err;
    logic       wb_irq_req;
    logic [25:0] other;
  } tx_descriptor_word0_t;

  // frame path result for one buffer
  typedef struct packed {
    logic              aborted;
    logic [STAT_W-1:0] frame_status_bits;
  } frame_result_t;

endpackage

// ==== verilog/tx_desc_status.sv ====
// builds the write-back value of descriptor word 0 from the fetched word and frame result
// assumes fetched word and result are stable while it is sampled
`timescale 1ns/1ns
module tx_desc_status
(
  // inputs
  input  wire tx_desc_pkg::tx_descriptor_word0_t fetched,
  input  wire tx_desc_pkg::frame_result_t        result,
  input  wire logic [7:0]                        status_copy_mask,
  // outputs
  output tx_desc_pkg::tx_descriptor_word0_t      writeback,
  output logic                                   frame_error_flag
);

  logic [7:0] low_events;

  always_comb
  begin
    // low status events can be masked, bit eight always counts
    low_events       = result.frame_status_bits[7:0] & ~status_copy_mask;
    frame_error_flag = (|low_events) | result.frame_status_bits[tx_desc_pkg::STAT_HI]
                       | result.aborted;
    writeback          = fetched;
    writeback.owned    = 1'b0;
    writeback.frame_err = frame_error_flag;
    writeback.other    = {fetched.other[25:tx_desc_pkg::STAT_W],
                          result.frame_status_bits};
  end

endmodule

// ==== dv/desc_mem_model.sv ====
// descriptor memory model: sixteen word-0 slots, one for each 16-byte stride
// assumes the handler holds req, addr and wdata until it samples ack
`timescale 1ns/1ns
module desc_mem_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lat,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  // slots are preloaded by the bench acting as software
  logic [31:0] mem [16];
  logic [1:0]  wait_ff = 2'h0;
  // read data toggles outside ack so a stale value cannot pass for a fresh one
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      wait_ff   <= 2'h0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ack)
    begin
      wait_ff <= wait_ff + 2'h1;
      if (wait_ff >= lat)
      begin
        mem_ack <= 1'b1;
        wait_ff <= 2'h0;
        mem_rdata <= mem[mem_addr[7:4]];
        if (mem_write)
          mem[mem_addr[7:4]] <= mem_wdata;
      end
    end
  end
endmodule

// ==== dv/tb_tx_descriptor_handler.sv ====
// testbench for the transmit descriptor handler with a memory model and a frame path driver
// assumes the memory model in desc_mem_model; inputs change on the falling edge
`timescale 1ns/1ns
module tb_tx_descriptor_handler;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
  logic                       clk = 1'b0, rst = 1'b1, tx_start = 1'b0, mode = 1'b0;
  logic                       frame_done = 1'b0, mem_req, mem_write, mem_ack;
  logic [31:0]                ring_base = 32'h40, mem_addr, mem_wdata, mem_rdata;
  logic [31:0]                last_rd = 32'h0, seed = 32'hF3B943EE;
  logic [7:0]                 mask = 8'h0;
  logic [1:0]                 lat = 2'h0, frame_pos;
  logic                       frame_start, first, last, irq, active, err_seen, err_or;
  tx_desc_pkg::frame_result_t frame_result = '0;
  logic [31:0]                exp_wb [6];
  int                         errors = 0, samples_checked = 0, irq_cnt = 0, exp_irq = 0;
  int                         rd_cnt = 0, exp_rd = 0;

  always #10 clk = ~clk;

  tx_descriptor_handler uut (.clk(clk), .rst(rst), .ce(1'b1), .tx_start(tx_start),
    .ring_base(ring_base), .status_copy_mask(mask), .tx_irq_mode_select(mode),
    .mem_req_ff(mem_req), .mem_write_ff(mem_write), .mem_addr_ff(mem_addr),
    .mem_wdata_ff(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .frame_start_ff(frame_start), .frame_position_ff(frame_pos), .frame_first_ff(first),
    .frame_last_ff(last), .frame_done(frame_done), .frame_result(frame_result),
    .writeback_irq_ff(irq), .active_ff(active), .frame_error_seen_ff(err_seen));

  desc_mem_model mem_m (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  always @(posedge clk)
  begin
    if (irq === 1'b1)
      irq_cnt++;
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_write === 1'b0)
    begin
      last_rd <= mem_addr;
      rd_cnt++;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected write-back: owner cleared, error flag, status in the low nine bits
  function automatic logic [31:0] wb(logic [31:0] w, tx_desc_pkg::frame_result_t r);
    logic e;
    e = |(r.frame_status_bits[7:0] & ~mask) | r.frame_status_bits[8] | r.aborted;
    return {1'b0, w[30:28], e, w[26:9], r.frame_status_bits};
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic kick();
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
  endtask

  // plays the frame path for one descriptor; sparse status so unmasked errors vary
  task automatic run_frame(input int idx);
    tx_desc_pkg::frame_result_t r;
    int                         n;
    r = 10'(rnd() & rnd() & rnd());
    n = 0;
    while (frame_start !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      results();
    end
    `CHK(frame_pos, mem_m.mem[idx][29:28])
    `CHK({first, last}, mem_m.mem[idx][29:28])
    repeat (rnd() % 4) @(negedge clk);
    frame_done = 1'b1;
    frame_result = r;
    @(negedge clk);
    frame_done = 1'b0;
    exp_wb[idx] = wb(mem_m.mem[idx], r);
    exp_irq += int'(mem_m.mem[idx][26] & mode);
    err_or = err_or | exp_wb[idx][27];
  endtask

  // walk must end on the unowned slot and then leave memory alone
  task automatic wait_idle(input logic [31:0] stop_addr);
    int n;
    n = 0;
    while (active !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      results();
    end
    repeat (8) @(negedge clk);
    `CHK(mem_req, 1'b0)
    `CHK(last_rd, stop_addr)
    `CHK(rd_cnt, exp_rd)
    `CHK(err_seen, err_or)
    `CHK(irq_cnt, exp_irq)
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    for (int k = 0; k < 5; k++)
    begin
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      mask = (k == 0) ? 8'hFF : 8'(rnd() | rnd());
      mode = k[0];
      lat = 2'(rnd());
      for (int i = 0; i < 6; i++)
        mem_m.mem[i] = {i < 3, i == 2, 30'(rnd())};
      err_or = 1'b0;
      kick();
      for (int i = 0; i < 3; i++)
        run_frame(i);
      // three owned slots, then the wrapped unowned slot, and no refetch after it
      exp_rd += 4;
      wait_idle(32'h40);
      for (int i = 0; i < 3; i++)
        `CHK(mem_m.mem[i], exp_wb[i])
      mem_m.mem[4][31] = 1'b1;
      mem_m.mem[4][30] = 1'b0;
      err_or = 1'b0;
      kick();
      run_frame(4);
      exp_rd += 2;
      wait_idle(32'h50);
      `CHK(mem_m.mem[4], exp_wb[4])
    end
    results();
  end
endmodule
